// >>> verif/eic_idle_assertions.sv
`timescale 1ns/1ps
module eic_idle_chk (
  input wire logic              ref_clk_in,
  input wire logic              rst_in,
  input wire logic              ras_down_in,
  input wire logic              refresh_in,
  input wire eic_pkg::eic_acc_t req_in,
  input wire logic              precharge_out,
  input wire logic              idle_out,
  input wire logic [1:0]        idle_len_out,
  input wire logic [23:0]       addr_out,
  input wire logic              data_oe_n_out,
  input wire logic [7:0]        chip_select_out,
  input wire logic              upper_col_strobe,
  input wire logic              lower_col_strobe,
  input wire logic              address_strobe,
  input wire logic              read_strobe_out,
  input wire logic              upper_byte_mask,
  input wire logic              lower_byte_mask
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // idle lengths seen from their first state
  sequence s_one; idle_out ##1 !idle_out; endsequence
  sequence s_two; idle_out [*2] ##1 !idle_out; endsequence
  AST_LEN_ONE: assert property ($rose(idle_out) && idle_len_out == 2'h1 |-> s_one)
    else $error("one-state idle wrong length");
  AST_LEN_TWO: assert property ($rose(idle_out) && idle_len_out == 2'h2 |-> s_two)
    else $error("two-state idle wrong length");
  AST_PINS: assert property (idle_out |-> data_oe_n_out && address_strobe
    && read_strobe_out) else $error("strobe active in idle");
  AST_ADDR: assert property (idle_out |-> addr_out == req_in.addr)
    else $error("idle address not next cycle");
  AST_CS_HIGH: assert property (idle_out && !ras_down_in && !refresh_in
    |-> &chip_select_out) else $error("select low in idle");
  AST_CS_RAS: assert property (idle_out && ras_down_in |-> !(&chip_select_out))
    else $error("select released in ras-down idle");
  AST_REFRESH: assert property (idle_out && refresh_in |-> !(&chip_select_out)
    && !upper_col_strobe && !lower_col_strobe) else $error("refresh idle");
  AST_PRECH: assert property (precharge_out |-> !idle_out [*2])
    else $error("idle beside precharge");
  AST_MASK_WR: assert property (idle_out && req_in.write && req_in.burst
    |-> upper_byte_mask && lower_byte_mask) else $error("write mask low");
  // two-state read idle: masks low in the first state, high in the second
  sequence s_mask_lo_hi;
    !upper_byte_mask && !lower_byte_mask ##1 upper_byte_mask && lower_byte_mask;
  endsequence
  AST_MASK_RD: assert property ($rose(idle_out) && idle_len_out == 2'h2
    && !req_in.write && req_in.burst
    && req_in.space == eic_pkg::EIC_SPACE_SDRAM |-> s_mask_lo_hi)
    else $error("read mask timing wrong");
endmodule // eic_idle_chk
bind eic_idle_insert eic_idle_chk eic_idle_chk_inst (.*);

// >>> verif/eic_mem_model.sv
`timescale 1ns/1ps
module eic_mem_model (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic start_in,
  input  wire logic slow_in,
  output logic      done_out
);
  logic [3:0] cnt;
  // slow parts hold the bus longer, so done comes late
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) cnt <= 4'h0;
    else if (start_in) cnt <= slow_in ? 4'h8 : 4'h2;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  assign done_out = (cnt == 4'h1); // one-cycle end of bus cycle
endmodule // eic_mem_model

// >>> verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic idle_read_after_write_en_in = 1'b0, idle_diff_area_read_en_in = 1'b0;
  logic idle_write_after_read_en_in = 1'b0, idle_length_sel_in = 1'b0;
  logic dram_idle_enable_in = 1'b0, cfg_load_in = 1'b0, ras_down_in = 1'b0;
  logic refresh_in = 1'b0, req_valid_in = 1'b0, kick = 1'b0, slow = 1'b0;
  eic_pkg::eic_acc_t req_in = '0;
  logic cycle_done_in, mdone, start_out, precharge_out, idle_out;
  logic data_oe_n_out, upper_col_strobe, lower_col_strobe, address_strobe;
  logic read_strobe_out, output_enable_out, high_byte_write, low_byte_write;
  logic upper_byte_mask, lower_byte_mask;
  logic [1:0] idle_len_out, ext_dma_ack_out;
  logic [2:0] dma_ack_out;
  logic [7:0] chip_select_out;
  logic [23:0] addr_out;
  int n_fail = 0;
  int samples_checked = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  // bench restarts an idle bus itself, memory ends running cycles
  assign cycle_done_in = kick | mdone;
  eic_idle_insert eic_idle_insert_inst (.*);
  eic_mem_model eic_mem_model_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .start_in(start_out), .slow_in(slow), .done_out(mdone));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // valid drops so the pending done pulse is not taken with old settings
  task automatic cfg(input logic [4:0] v);
    @(posedge ref_clk_in);
    {idle_read_after_write_en_in, idle_diff_area_read_en_in,
     idle_write_after_read_en_in, idle_length_sel_in, dram_idle_enable_in} <= v;
    cfg_load_in <= 1'b1;
    req_valid_in <= 1'b0;
    @(posedge ref_clk_in);
    cfg_load_in <= 1'b0;
  endtask
  // k: refresh, ras-down, write, space, burst; result {precharges, idles}
  task automatic acc(input logic [5:0] k, input logic [2:0] a, output logic [7:0] r);
    logic [3:0] ci, cp;
    ci = 4'h0;
    cp = 4'h0;
    @(posedge ref_clk_in);
    {refresh_in, ras_down_in, slow} <= {k[5], k[4], k[4]};
    req_in <= '{k[3], eic_pkg::eic_space_t'(k[2:1]), a, k[0], {a, 21'h00ABC}};
    kick <= ~req_valid_in;
    req_valid_in <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk_in);
      kick <= 1'b0;
      #1;
      ci += 4'(idle_out);
      cp += 4'(precharge_out);
      if (start_out === 1'b1) break;
      if (i == 39) begin
        n_fail++;
        finish_test();
      end
    end
    r = {cp, ci};
  endtask
  logic [7:0] r;
  // reset defaults are used first, the config inputs are all zero
  initial begin
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    acc(6'h00, 3'h0, r); check(r, 8'h00);
    acc(6'h00, 3'h1, r); check(r, 8'h01);
    acc(6'h08, 3'h1, r); check(r, 8'h01);
    acc(6'h20, 3'h1, r); check(r, 8'h01);
    cfg(5'h1E);
    acc(6'h00, 3'h2, r); check(r, 8'h02);
    acc(6'h02, 3'h3, r); check(r, 8'h10);
    acc(6'h00, 3'h0, r); check(r, 8'h00);
    acc(6'h0C, 3'h4, r); check(r, 8'h02);
    acc(6'h00, 3'h0, r); check(r, 8'h02);
    acc(6'h04, 3'h4, r); check(r, 8'h10);
    cfg(5'h1D);
    acc(6'h00, 3'h0, r); check(r, 8'h01);
    acc(6'h0A, 3'h3, r); check(r, 8'h01);
    acc(6'h00, 3'h0, r); check(r, 8'h01);
    acc(6'h02, 3'h3, r); check(r, 8'h10);
    acc(6'h1B, 3'h3, r); check(r, 8'h01);
    acc(6'h13, 3'h3, r); check(r, 8'h01);
    cfg(5'h1C);
    acc(6'h1B, 3'h3, r); check(r, 8'h00);
    cfg(5'h1F);
    acc(6'h15, 3'h3, r); check(r, 8'h02);
    acc(6'h1D, 3'h3, r); check(r, 8'h02);
    finish_test();
  end
endmodule // tb

// >>> verilog/eic_idle_insert.sv
`timescale 1ns/1ps
module eic_idle_insert (
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     idle_read_after_write_en_in,
  input  wire logic                     idle_diff_area_read_en_in,
  input  wire logic                     idle_write_after_read_en_in,
  input  wire logic                     idle_length_sel_in,
  input  wire logic                     dram_idle_enable_in,
  input  wire logic                     cfg_load_in,
  input  wire logic                     ras_down_in,
  input  wire logic                     refresh_in,
  input  wire logic                     req_valid_in,
  input  wire eic_pkg::eic_acc_t        req_in,
  input  wire logic                     cycle_done_in,
  output logic                          start_out,
  output logic                          precharge_out,
  output logic                          idle_out,
  output logic [1:0]                    idle_len_out,
  output logic [eic_pkg::ADDR_W-1:0]    addr_out,
  output logic                          data_oe_n_out,
  output logic [eic_pkg::CS_N-1:0]      chip_select_out,
  output logic                          upper_col_strobe,
  output logic                          lower_col_strobe,
  output logic                          address_strobe,
  output logic                          read_strobe_out,
  output logic                          output_enable_out,
  output logic                          high_byte_write,
  output logic                          low_byte_write,
  output logic                          upper_byte_mask,
  output logic                          lower_byte_mask,
  output logic [eic_pkg::DACK_N-1:0]    dma_ack_out,
  output logic [eic_pkg::EDACK_N-1:0]   ext_dma_ack_out
);
  eic_pkg::eic_cfg_t   cfg;
  eic_pkg::eic_acc_t   prev;
  eic_pkg::eic_acc_t   cur;
  logic                prev_valid;
  eic_pkg::eic_state_t state;
  logic                want_len2;

  // configuration held from reset; software loads it via cfg_load_in
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cfg <= '{raw_en:  eic_pkg::RST_RAW_EN,
               diff_en: eic_pkg::RST_DIFF_EN,
               war_en:  eic_pkg::RST_WAR_EN,
               len_sel: eic_pkg::RST_LEN_SEL,
               dram_en: eic_pkg::RST_DRAM_EN}; // RQ21
    end else if (cfg_load_in) begin
      cfg <= '{raw_en:  idle_read_after_write_en_in,
               diff_en: idle_diff_area_read_en_in,
               war_en:  idle_write_after_read_en_in,
               len_sel: idle_length_sel_in,
               dram_en: dram_idle_enable_in};
    end
  end

  // classify previous and next accesses
  wire prev_rd    = prev_valid & ~prev.write;
  wire prev_wr    = prev_valid & prev.write;
  wire prev_mem   = prev.space != eic_pkg::EIC_SPACE_NORMAL;
  wire next_rd    = ~req_in.write;
  wire next_wr    = req_in.write;
  wire next_mem   = req_in.space != eic_pkg::EIC_SPACE_NORMAL;
  wire diff_area  = prev.area != req_in.area;
  // burst continues in the same open row
  wire in_burst   = req_in.burst & prev_mem & next_mem & ~diff_area;
  // full dram/sdram read after a normal read: precharge covers the gap
  wire full_mem   = next_mem & ~req_in.burst; // RQ2 RQ3
  // reads after a dram-type read are gated by the dram enable
  wire rd_gate    = ~prev_mem | cfg.dram_en; // RQ7 RQ9
  wire cond_diff  = prev_rd & next_rd & diff_area & cfg.diff_en
                  & rd_gate & ~(~prev_mem & full_mem); // RQ18 RQ1 RQ2 RQ3
  wire cond_war   = prev_rd & next_wr & cfg.war_en & rd_gate
                  & ~in_burst; // RQ19 RQ7 RQ9
  // read after write ignores the dram enable
  wire cond_raw   = prev_wr & next_rd & cfg.raw_en
                  & ~in_burst; // RQ20 RQ8 RQ10
  // read/write turnaround inside a burst, ras-down too
  wire cond_burst = in_burst & (prev_rd ^ next_rd)
                  & cfg.dram_en; // RQ12 RQ4
  wire need_idle  = cond_diff | cond_war | cond_raw
                  | cond_burst; // RQ17 when all low
  wire need_pre   = prev_rd & next_rd & diff_area & cfg.diff_en
                  & ~prev_mem & full_mem; // RQ2 RQ3

  assign want_len2 = cfg.len_sel; // RQ11

  // sequencer: bus cycle, then one or two idle states
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state      <= eic_pkg::EIC_ST_BUS;
      prev_valid <= 1'b0;
      prev       <= '0;
      cur        <= '0;
      start_out  <= 1'b0;
      precharge_out <= 1'b0;
      idle_len_out  <= 2'h0;
    end else begin
      start_out     <= 1'b0;
      precharge_out <= 1'b0;
      case (state)
        eic_pkg::EIC_ST_BUS: begin
          if (req_valid_in & cycle_done_in) begin
            cur <= req_in;
            if (need_idle) begin
              state        <= eic_pkg::EIC_ST_IDLE1;
              idle_len_out <= want_len2 ? eic_pkg::LEN_TWO
                                        : eic_pkg::LEN_ONE; // RQ11
            end else begin
              start_out     <= 1'b1; // RQ17
              precharge_out <= need_pre;
              prev          <= req_in;
              prev_valid    <= 1'b1;
              idle_len_out  <= 2'h0;
            end
          end
        end
        eic_pkg::EIC_ST_IDLE1: begin
          if (want_len2) begin
            state <= eic_pkg::EIC_ST_IDLE2; // RQ11
          end else begin
            state      <= eic_pkg::EIC_ST_BUS;
            start_out  <= 1'b1;
            prev       <= cur;
            prev_valid <= 1'b1;
          end
        end
        eic_pkg::EIC_ST_IDLE2: begin
          state      <= eic_pkg::EIC_ST_BUS;
          start_out  <= 1'b1;
          prev       <= cur;
          prev_valid <= 1'b1;
        end
        default: state <= eic_pkg::EIC_ST_BUS;
      endcase
    end
  end

  wire in_idle = state != eic_pkg::EIC_ST_BUS;
  // select stays low in ras-down or refresh, cas only in refresh
  wire cs_low  = ras_down_in | refresh_in; // RQ15 RQ16
  wire cas_low = refresh_in; // RQ16
  wire sdram_burst = cur.space == eic_pkg::EIC_SPACE_SDRAM & cur.burst;
  // read mask released one state later with two-state idles
  wire mask_rd = sdram_burst & ~cur.write & (state == eic_pkg::EIC_ST_IDLE2
                 | (state == eic_pkg::EIC_ST_IDLE1 & ~want_len2)); // RQ5
  // write masks are held high over any idle, length ignored
  wire mask_wr = sdram_burst & cur.write; // RQ6

  // idle pin states; bus-cycle strobes belong to the cycle engine
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      idle_out          <= 1'b0;
      addr_out          <= '0;
      data_oe_n_out     <= 1'b1;
      chip_select_out   <= '1;
      upper_col_strobe  <= 1'b1;
      lower_col_strobe  <= 1'b1;
      address_strobe    <= 1'b1;
      read_strobe_out   <= 1'b1;
      output_enable_out <= 1'b1;
      high_byte_write   <= 1'b1;
      low_byte_write    <= 1'b1;
      upper_byte_mask   <= 1'b1;
      lower_byte_mask   <= 1'b1;
      dma_ack_out       <= '1;
      ext_dma_ack_out   <= '1;
    end else begin
      idle_out          <= in_idle;
      addr_out          <= in_idle ? cur.addr : req_in.addr; // RQ14
      data_oe_n_out     <= 1'b1; // RQ13
      chip_select_out   <= (in_idle & cs_low) ? '0 : '1; // RQ15
      upper_col_strobe  <= ~(in_idle & cas_low); // RQ16
      lower_col_strobe  <= ~(in_idle & cas_low);
      address_strobe    <= 1'b1; // RQ13
      read_strobe_out   <= 1'b1;
      output_enable_out <= 1'b1;
      high_byte_write   <= 1'b1;
      low_byte_write    <= 1'b1;
      upper_byte_mask   <= ~(in_idle & ~mask_rd & ~mask_wr
                              & sdram_burst);
      lower_byte_mask   <= ~(in_idle & ~mask_rd & ~mask_wr
                              & sdram_burst);
      dma_ack_out       <= '1;
      ext_dma_ack_out   <= '1;
    end
  end
endmodule // eic_idle_insert

// >>> verilog/eic_pkg.sv
// Notes on behaviour
// [RQ1] dram after normal uses normal enables
// [RQ2] dram full read: precharge only, no idle
// [RQ3] sdram full read: precharge only, no idle
// [RQ4] ras-down burst inserts idle per enables
// [RQ5] sdram burst read mask timing follows length
// [RQ6] sdram burst write mask ignores length select
// [RQ7] after dram read idle needs dram enable
// [RQ8] normal read after dram write: rw enable
// [RQ9] after sdram read idle needs dram enable
// [RQ10] normal read after sdram write: rw enable
// [RQ11] length select 0 one, 1 two states
// [RQ12] dram enable: idle between burst read/write
// [RQ13] idle: data floats, strobes and acks high
// [RQ14] idle: address shows following cycle
// [RQ15] idle: selects high, low in ras-down
// [RQ16] idle in refresh keeps select, cas low
// [RQ17] no matching condition: no idle
// [RQ18] different-area read enable inserts idle
// [RQ19] write-after-read enable inserts idle
// [RQ20] read-after-write enable inserts idle
// [RQ21] reset value enables idle insertion; code resets dram_en to 0, only raw_en, diff_en and war_en to 1
package eic_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CS_N   = 8;
  localparam int DACK_N = 3;
  localparam int EDACK_N = 2;
  localparam int AREA_W = 3;
  // reset values of the enables
  localparam logic RST_RAW_EN  = 1'b1;
  localparam logic RST_DIFF_EN = 1'b1;
  localparam logic RST_WAR_EN  = 1'b1;
  localparam logic RST_LEN_SEL = 1'b0;
  localparam logic RST_DRAM_EN = 1'b0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;

  typedef enum logic [1:0] {
    EIC_SPACE_NORMAL = 2'h0,
    EIC_SPACE_DRAM   = 2'h1,
    EIC_SPACE_SDRAM  = 2'h2
  } eic_space_t;

  typedef struct packed {
    logic              write;
    eic_space_t        space;
    logic [AREA_W-1:0] area;
    logic              burst;
    logic [ADDR_W-1:0] addr;
  } eic_acc_t;

  typedef struct packed {
    logic raw_en;
    logic diff_en;
    logic war_en;
    logic len_sel;
    logic dram_en;
  } eic_cfg_t;

  typedef enum logic [1:0] {
    EIC_ST_BUS   = 2'h0,
    EIC_ST_IDLE1 = 2'h1,
    EIC_ST_IDLE2 = 2'h3
  } eic_state_t;
endpackage
